// ### dv/testbench.sv
// Self-checking bench for the input capture unit.
// Assumes the far-side model drives pins and counter; the bench is the CPU.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, nrst, pin_set, cmp_set, irq_ack, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire logic pin, cmp, irq;
  wire logic [7:0] rdata;
  wire logic [15:0] count, cap;
  wire logic [3:0] wave_mode;
  int n_errors = 0;
  int tests_run = 0;
  tic_partner tic_partner_i (.clock(clock), .nrst(nrst), .pin_set(pin_set),
    .cmp_set(cmp_set), .pin(pin), .cmp(cmp), .count(count));
  tic_capture tic_capture_i (.clock(clock), .nrst(nrst), .capture_input_pin(pin),
    .comparator_output(cmp), .counter_value(count), .irq_ack(irq_ack), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capture_irq(irq),
    .capture_value_register(cap), .waveform_mode_select(wave_mode));
  // The clock toggles every 10 ns.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_reg
  // Waits a bounded time for a capture; a hit must hold the counter of its edge.
  task automatic wait_cap(input logic hit);
    logic [15:0] old;
    logic seen;
    old = cap;
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clock);
      #1;
      seen = (cap !== old);
    end
    check("capture seen", {15'h0000, hit}, {15'h0000, seen});
    if (hit && !seen) begin
      report_and_stop();
    end else if (hit) begin
      check("captured count", count - 16'h0001, cap);
      check("flag with capture", 16'h0001, {15'h0000, irq});
    end
  endtask : wait_cap
  task automatic t_pin_rise;
    check("reset capture", 16'h0000, cap);
    rd_reg(tic_pkg::ADDR_STATUS, 8'h00, "reset status");
    wr_reg(tic_pkg::ADDR_MASK, 8'h01);
    wr_reg(tic_pkg::ADDR_CTRL, 8'h01);
    pin_set <= 1'b1;
    wait_cap(1'b1);
    rd_reg(tic_pkg::ADDR_CAP_LOW, cap[7:0], "low byte");
    rd_reg(tic_pkg::ADDR_CAP_HIGH, cap[15:8], "high byte");
    wr_reg(tic_pkg::ADDR_STATUS, 8'h00);
    check("flag after zero", 16'h0001, {15'h0000, irq});
    wr_reg(tic_pkg::ADDR_STATUS, 8'h01);
    check("flag after one", 16'h0000, {15'h0000, irq});
  endtask : t_pin_rise
  task automatic t_fall_mask_ack;
    wr_reg(tic_pkg::ADDR_CTRL, 8'h00);
    pin_set <= 1'b0;
    wait_cap(1'b1);
    wr_reg(tic_pkg::ADDR_MASK, 8'h00);
    check("masked request", 16'h0000, {15'h0000, irq});
    wr_reg(tic_pkg::ADDR_MASK, 8'h01);
    @(posedge clock);
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
    #1;
    check("flag after service", 16'h0000, {15'h0000, irq});
    pin_set <= 1'b1;
    wait_cap(1'b0);
  endtask : t_fall_mask_ack
  task automatic t_comparator;
    wr_reg(tic_pkg::ADDR_CTRL, 8'h03);
    pin_set <= 1'b0;
    repeat (10) @(posedge clock);
    pin_set <= 1'b1;
    wait_cap(1'b0);
    // Acknowledge held across the capture edge: the set must win.
    irq_ack <= 1'b1;
    cmp_set <= 1'b1;
    wait_cap(1'b1);
    irq_ack <= 1'b0;
    wr_reg(tic_pkg::ADDR_STATUS, 8'h01);
  endtask : t_comparator
  // Every mode: high then low write lands only in the four top modes.
  task automatic t_top_write;
    logic [15:0] exp;
    for (int m = 0; m < 16; m++) begin
      exp = cap;
      wr_reg(tic_pkg::ADDR_CTRL, {m[3:0], 4'h3});
      check("mode", {12'h000, m[3:0]}, {12'h000, wave_mode});
      wr_reg(tic_pkg::ADDR_CAP_HIGH, {4'h3, m[3:0]});
      wr_reg(tic_pkg::ADDR_CAP_LOW, 8'hA5 ^ m[7:0]);
      if (m == 8 || m == 10 || m == 12 || m == 14)
        exp = {4'h3, m[3:0], 8'hA5 ^ m[7:0]};
      check("top write", exp, cap);
    end
    rd_reg(4'hF, 8'h00, "unmapped read");
  endtask : t_top_write
  // Reset for three cycles, then run the scenarios in order.
  initial begin
    nrst = 1'b0;
    pin_set = 1'b0;
    cmp_set = 1'b0;
    irq_ack = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_pin_rise();
    t_fall_mask_ack();
    t_comparator();
    t_top_write();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ### dv/tic_partner.sv
// Far-side model: capture pin, comparator output and the running counter.
// Assumes the bench sets the wanted levels; they reach the pins off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module tic_partner (
  input  wire logic        clock,   // System clock.
  input  wire logic        nrst,    // Reset, active low.
  input  wire logic        pin_set, // Wanted capture pin level.
  input  wire logic        cmp_set, // Wanted comparator level.
  output wire logic        pin,     // Capture pin.
  output wire logic        cmp,     // Comparator output.
  output var  logic [15:0] count    // Running counter.
);
  // Levels land 7 ns late, so they are unrelated to the clock edge.
  assign #7 pin = pin_set;
  assign #7 cmp = cmp_set;
  // The counter steps every cycle, so each capture sees a distinct value.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      count <= 16'h0000;
    else
      count <= count + 16'h0001;
  end
endmodule : tic_partner
`default_nettype wire

// ### logic/tic_capture.sv
// Input capture unit: edge detect, 16-bit snapshot, flag, byte-wide access.
// Assumes counter_value and irq_ack are synchronous to clock.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tic_capture (
  input  wire logic        clock,             // System clock, 50 MHz.
  input  wire logic        nrst,              // Asynchronous reset, active low.
  input  wire logic        capture_input_pin, // External capture pin.
  input  wire logic        comparator_output, // Analog comparator output, asynchronous.
  input  wire logic [15:0] counter_value,     // Running counter.
  input  wire logic        irq_ack,           // Pulse when the capture interrupt executes.
  input  wire logic [3:0]  addr,              // Register address.
  input  wire logic [7:0]  wdata,             // Write data.
  input  wire logic        wr,                // Write strobe.
  input  wire logic        rd,                // Read strobe.
  output var  logic [7:0]  rdata,             // Read data, one cycle after rd.
  output logic             capture_irq,       // Capture interrupt request.
  output var  logic [15:0] capture_value_register, // Captured or top value.
  output var  logic [3:0]  waveform_mode_select    // Waveform generation mode.
);
  logic        pin_level;
  logic        cmp_level;
  logic        trig_prev;
  logic [7:0]  ctrl;
  logic [7:0]  mask;
  logic        capture_flag;
  logic [7:0]  hold;
  logic        comparator_capture_select;
  logic        edge_rising;
  logic        capture_irq_enable;
  logic        trig;
  logic        capture_event;
  logic        top_mode;
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic        rd_low;
  logic        rd_high;
  logic        flag_clear;
  logic        next_flag;
  logic [7:0]  next_rdata;

  // Pin and comparator both pass the three-flop filter.
  tic_sync u_pin (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (capture_input_pin),
    .level    (pin_level)
  );
  tic_sync u_cmp (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (comparator_output),
    .level    (cmp_level)
  );

  // Tells whether a mode takes its top value from the capture register.
  function automatic logic uses_cap_top(input logic [3:0] m);
    uses_cap_top = (m == tic_pkg::MODE_TOP_A) || (m == tic_pkg::MODE_TOP_B) ||
                   (m == tic_pkg::MODE_TOP_C) || (m == tic_pkg::MODE_TOP_D);
  endfunction : uses_cap_top

  // Control fields.
  assign comparator_capture_select = ctrl[tic_pkg::CTRL_CMPSEL_BIT];
  assign edge_rising        = ctrl[tic_pkg::CTRL_EDGE_BIT];
  assign capture_irq_enable = mask[tic_pkg::MASK_IE_BIT];
  assign top_mode           = uses_cap_top(waveform_mode_select);

  // Source select and edge qualification.
  assign trig = comparator_capture_select ? cmp_level : pin_level;
  assign capture_event = (trig != trig_prev) && (trig == edge_rising);

  // Address decode.
  assign wr_low  = wr && (addr == tic_pkg::ADDR_CAP_LOW);
  assign wr_high = wr && (addr == tic_pkg::ADDR_CAP_HIGH);
  assign wr_ctrl = wr && (addr == tic_pkg::ADDR_CTRL);
  assign wr_stat = wr && (addr == tic_pkg::ADDR_STATUS);
  assign wr_mask = wr && (addr == tic_pkg::ADDR_MASK);
  assign rd_low  = rd && (addr == tic_pkg::ADDR_CAP_LOW);
  assign rd_high = rd && (addr == tic_pkg::ADDR_CAP_HIGH);

  // Flag: a capture in the clearing cycle wins over the clear.
  assign flag_clear = irq_ack || (wr_stat && wdata[tic_pkg::STAT_FLAG_BIT]);
  assign next_flag  = capture_event ? 1'b1 : (flag_clear ? 1'b0 : capture_flag);
  assign capture_irq = capture_flag && capture_irq_enable;

  // Read multiplexer; unmapped addresses read zero.
  assign next_rdata = rd_low  ? capture_value_register[7:0] :
                      rd_high ? hold :
                      (rd && addr == tic_pkg::ADDR_CTRL)   ? ctrl :
                      (rd && addr == tic_pkg::ADDR_STATUS) ? {7'h00, capture_flag} :
                      (rd && addr == tic_pkg::ADDR_MASK)   ? mask : 8'h00;

  // Edge history, flag and read data.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig_prev    <= 1'b0;
      capture_flag <= 1'b0;
      rdata        <= 8'h00;
    end else begin
      trig_prev    <= trig;
      capture_flag <= next_flag;
      rdata        <= next_rdata;
    end
  end

  // Configuration registers.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl                 <= tic_pkg::CTRL_RESET;
      mask                 <= tic_pkg::MASK_RESET;
      waveform_mode_select <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl                 <= wdata;
        waveform_mode_select <= wdata[tic_pkg::CTRL_MODE_LSB +: 4];
      end
      if (wr_mask) begin
        mask <= wdata;
      end
    end
  end

  // Holding register: filled by a high-byte write or a low-byte read.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hold <= 8'h00;
    end else if (wr_high) begin
      hold <= wdata;
    end else if (rd_low) begin
      hold <= capture_value_register[15:8];
    end
  end

  // Capture register: capture snapshot, or a gated 16-bit software write.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      capture_value_register <= tic_pkg::CAP_RESET;
    end else if (capture_event) begin
      capture_value_register <= counter_value;
    end else if (wr_low && top_mode) begin
      capture_value_register <= {hold, wdata};
    end
  end

  // Checks: the flag and the snapshot land together, and a set beats a clear.
  sequence s_capture;
    capture_event;
  endsequence

  sequence s_flag_and_value;
    capture_flag && capture_value_register == $past(counter_value);
  endsequence

  sequence s_low_read;
    rd_low && !wr_high;
  endsequence

  chk_flag_with_value: assert property (@(posedge clock) disable iff (!nrst)
    s_capture |=> s_flag_and_value)
    else $error("Capture flag and value not set together.");

  chk_set_wins: assert property (@(posedge clock) disable iff (!nrst)
    capture_event && flag_clear |=> capture_flag)
    else $error("A clear in the capture cycle beat the capture.");

  // The request follows a fresh capture only while it is enabled.
  chk_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
    capture_event && capture_irq_enable && !wr_mask |=> capture_irq)
    else $error("Capture with the enable set raised no request.");

  chk_irq_masked: assert property (@(posedge clock) disable iff (!nrst)
    !capture_irq_enable |-> !capture_irq)
    else $error("Request raised while the enable is clear.");

  chk_ack_clear: assert property (@(posedge clock) disable iff (!nrst)
    irq_ack && !capture_event |=> !capture_flag)
    else $error("Flag not cleared by interrupt service.");

  chk_sw_clear: assert property (@(posedge clock) disable iff (!nrst)
    wr_stat && !capture_event |=> capture_flag == ($past(capture_flag) &&
      !$past(wdata[0]) && !$past(irq_ack)))
    else $error("Software clear of flag misbehaved.");

  // A low read fills the holding byte, a high read returns it, and idle reads give zero.
  chk_hold_latch: assert property (@(posedge clock) disable iff (!nrst)
    s_low_read |=> hold == $past(capture_value_register[15:8]))
    else $error("Low byte read did not latch the high byte.");

  chk_high_read: assert property (@(posedge clock) disable iff (!nrst)
    rd_high |=> rdata == $past(hold))
    else $error("High byte read did not return the holding register.");

  chk_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
    !rd |=> rdata == 8'h00)
    else $error("Read data not zero outside a read answer.");

  chk_write_gate: assert property (@(posedge clock) disable iff (!nrst)
    wr_low && !top_mode && !capture_event |=> $stable(capture_value_register))
    else $error("Capture register written outside a top mode.");

  // Writes: the high byte waits in the holding register, the mode field follows control.
  chk_hold_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_high |=> hold == $past(wdata))
    else $error("High byte write did not load the holding register.");

  chk_word_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_low && top_mode && !capture_event |=>
      capture_value_register == {$past(hold), $past(wdata)})
    else $error("Low byte write did not load the full word.");

  chk_mode_field: assert property (@(posedge clock) disable iff (!nrst)
    wr_ctrl |=> waveform_mode_select == $past(wdata[tic_pkg::CTRL_MODE_LSB +: 4]))
    else $error("Waveform mode field does not follow the control write.");

  chk_edge_polarity: assert property (@(posedge clock) disable iff (!nrst)
    capture_event |-> trig == edge_rising && $past(trig) != edge_rising)
    else $error("Capture on the wrong edge.");

  // A rising edge on the selected source under steady control must capture.
  chk_source_sel: assert property (@(posedge clock) disable iff (!nrst)
    !$changed(ctrl) && edge_rising &&
      (comparator_capture_select ? $rose(cmp_level) : $rose(pin_level)) |-> capture_event)
    else $error("Rising edge on the selected source gave no capture.");
endmodule : tic_capture
`default_nettype wire

// ### logic/tic_pkg.sv
// Constants, register map and field layout of the timer input capture unit.
// Assumes a byte-wide register port with read data one cycle after the strobe.
package tic_pkg;
  localparam logic [3:0] ADDR_CAP_LOW  = 4'h0;
  localparam logic [3:0] ADDR_CAP_HIGH = 4'h1;
  localparam logic [3:0] ADDR_CTRL     = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_MASK     = 4'h4;
  localparam int CTRL_EDGE_BIT  = 0;
  localparam int CTRL_CMPSEL_BIT = 1;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int STAT_FLAG_BIT  = 0;
  localparam int MASK_IE_BIT    = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [3:0] MODE_TOP_A = 4'h8;
  localparam logic [3:0] MODE_TOP_B = 4'hA;
  localparam logic [3:0] MODE_TOP_C = 4'hC;
  localparam logic [3:0] MODE_TOP_D = 4'hE;
endpackage : tic_pkg

// ### logic/tic_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous input.
// Assumes the input may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module tic_sync (
  input  wire logic clock,    // System clock.
  input  wire logic nrst,     // Asynchronous reset, active low.
  input  wire logic async_in, // Raw pin level.
  output var  logic level     // Filtered synchronous level.
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // A change counts only when the second and third stages agree.
  assign next_level = (s2 == s3) ? s3 : level;

  // Shift the pin through three flops; the first is read only by the second.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= async_in;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule : tic_sync
`default_nettype wire
